/* hw/usr_map.svh */
`ifndef USR_MAP_SVH
`define USR_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define USR_A_CFG   12'h000
`define USR_A_CTL   12'h004
`define USR_A_STAT  12'h008
`define USR_A_INTEN 12'h00c
`define USR_A_RXDAT 12'h014
`define USR_A_RXDST 12'h018
`define USR_A_TXDAT 12'h01c
`define USR_A_BRG   12'h020
`define USR_A_OSR   12'h028

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define USR_CFG_EN    0
`define USR_CFG_DLEN  2
`define USR_CFG_PAR   4
`define USR_CFG_STOP2 6
`define USR_CFG_M32K  7
`define USR_CFG_CTSEN 9
`define USR_CFG_SYNC  11
`define USR_CFG_SPOL  12
`define USR_CFG_SMST  14
`define USR_CFG_LOOP  15
`define USR_CFG_OESEL 20
`define USR_CFG_MASK  32'h0010dafd
`define USR_DLEN_8    2'h1
`define USR_DLEN_9    2'h2

// ----------------------------------------
// control fields
// ----------------------------------------
`define USR_CTL_TXBRK 1
`define USR_CTL_ADET  2
`define USR_CTL_TXDIS 6
`define USR_CTL_CC    8
`define USR_CTL_ABAUD 16
`define USR_CTL_MASK  32'h00010146

// ----------------------------------------
// status fields
// ----------------------------------------
`define USR_ST_RXRDY  0
`define USR_ST_RXIDLE 1
`define USR_ST_TXRDY  2
`define USR_ST_TXIDLE 3
`define USR_ST_CTS    4
`define USR_ST_DCTS   5
`define USR_ST_TXDIS  6
`define USR_ST_OVR    8
`define USR_ST_UNR    9
`define USR_ST_RXBRK  10
`define USR_ST_DBRK   11
`define USR_ST_FRM    13
`define USR_ST_PAR    14
`define USR_ST_NOISE  15
`define USR_ST_ABERR  16
`define USR_ST_W1C    32'h0001eb20
`define USR_IEN_MASK  32'h0001eb2f

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define USR_OSR_RST 4'hf
`define USR_OSR_MIN 4'h4

`endif

/* hw/usr_pkg.sv */
`default_nettype none
package usr_pkg;
	typedef enum logic {TX_IDLE, TX_SEND} usr_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_BRK} usr_rx_st_t;
endpackage
`default_nettype wire

/* hw/usr_top.sv */
// Overview of operation
// - seven, eight or nine data bits; one/two stops
// - parity odd, even or none
// - oversampling factor five to sixteen clocks
// - two-of-three vote; noise flag on disagreement
// - one transmit and one receive buffer
// - cts pauses transmit; rts throttles receive
// - cts change flag; transmit disable control
// - ninth bit marks multidrop address characters
// - rs-485 driver enable around own transmissions
// - autobaud measures start bit, loads divider
// - synchronous master/slave, phase, continuous clock
// - send break; detect break and flag changes
// - individually enabled interrupt sources
// - loopback of data and flow control
// - character plus status in one read
// - 32 kHz clocked mode that wakes
// - wake only in sync, 32k, cts-irq
// - separate receive and transmit dma requests
// - baud source is shared fractional divider, or the 32 kHz tick in 32k mode
// - rates up to 4.5/15/18 Mbit/s
`timescale 1ns/1ns
`default_nettype none
`include "usr_map.svh"

module usr_top
	import usr_pkg::*;
#(
	parameter int BRG_W = 16
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// baud sources
	input  wire logic              frg_tick,
	input  wire logic              rtc_tick,
	// serial line and flow control
	input  wire logic              rxd,
	output logic                   txd,
	input  wire logic              cts_n,
	output logic                   rts_n,
	output logic                   drv_oe,
	// synchronous clock pin
	input  wire logic              sclk_i,
	output logic                   sclk_o,
	output logic                   sclk_oe,
	// dma and events
	output logic                   rx_req,
	output logic                   tx_req,
	output logic                   intr,
	output logic                   wake
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (BRG_W < 4 || BRG_W > 16) begin : g_chk
		$error("BRG_W must lie in 4..16");
	end

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	logic [31:0]      cfg;
	logic [31:0]      ctl;
	logic [31:0]      inten;
	logic [31:0]      stk;
	logic [BRG_W-1:0] brg;
	logic [BRG_W-1:0] bcnt;
	logic [3:0]       osr;
	logic [8:0]       txbuf;
	logic             txrdy;
	logic [8:0]       rxbuf;
	logic [2:0]       rxst;
	logic             rxrdy;
	usr_tx_st_t       tst;
	logic [12:0]      tsh;
	logic [3:0]       tleft;
	logic [3:0]       tos;
	usr_rx_st_t       rst;
	logic [3:0]       ros;
	logic [3:0]       ridx;
	logic [8:0]       rsh;
	logic             rpar;
	logic             rzero;
	logic             nz;
	logic             s1;
	logic             s2;
	logic             sck_q;
	logic             cts_q;
	logic             brk_q;
	logic             ab_on;
	logic [3:0]       ab_sub;
	logic [BRG_W:0]   ab_cnt;

	// ----------------------------------------
	// frame builder
	// ----------------------------------------
	function automatic logic [12:0] usr_frame(input logic [8:0] d,
		input logic [3:0] n, input logic pe, input logic po);
		logic [12:0] f;
		logic        p;
		f = '1;
		f[0] = 1'b0;
		p = po;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				f[i+1] = d[i];
				p = p ^ d[i];
			end
		end
		if (pe) begin
			f[n+4'h1] = p;
		end
		return f;
	endfunction

	// ----------------------------------------
	// configuration decode
	// ----------------------------------------
	wire       en     = cfg[`USR_CFG_EN];
	wire [1:0] dsel   = cfg[`USR_CFG_DLEN+:2];
	wire       par_en = cfg[`USR_CFG_PAR+1];
	wire       par_od = cfg[`USR_CFG_PAR];
	wire       stop2  = cfg[`USR_CFG_STOP2];
	wire       m32k   = cfg[`USR_CFG_M32K];
	wire       ctsen  = cfg[`USR_CFG_CTSEN];
	wire       sync   = cfg[`USR_CFG_SYNC];
	wire       spol   = cfg[`USR_CFG_SPOL];
	wire       smst   = cfg[`USR_CFG_SMST];
	wire       loop   = cfg[`USR_CFG_LOOP];
	wire       oesel  = cfg[`USR_CFG_OESEL];
	wire       txbrk  = ctl[`USR_CTL_TXBRK];
	wire       adet   = ctl[`USR_CTL_ADET];
	wire       txdis  = ctl[`USR_CTL_TXDIS];
	wire       ccont  = ctl[`USR_CTL_CC];
	wire       abaud  = ctl[`USR_CTL_ABAUD];
	wire [3:0] dlen = (dsel == `USR_DLEN_9) ? 4'h9 :
		(dsel == `USR_DLEN_8) ? 4'h8 : 4'h7;
	wire [3:0] sp   = dlen + {3'h0, par_en} + 4'h1;
	wire [3:0] flen = sp + {3'h0, stop2} + 4'h1;
	wire [3:0] mid  = {1'b0, osr[3:1]};

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire setup  = psel & ~penable;
	wire acc    = psel & penable & pready;
	wire wr     = acc & pwrite;
	wire h_cfg  = paddr == `USR_A_CFG;
	wire h_ctl  = paddr == `USR_A_CTL;
	wire h_stat = paddr == `USR_A_STAT;
	wire h_ien  = paddr == `USR_A_INTEN;
	wire h_rxd  = paddr == `USR_A_RXDAT;
	wire h_rxs  = paddr == `USR_A_RXDST;
	wire h_txd  = paddr == `USR_A_TXDAT;
	wire h_brg  = paddr == `USR_A_BRG;
	wire h_osr  = paddr == `USR_A_OSR;
	wire mapped = h_cfg | h_ctl | h_stat | h_ien | h_rxd | h_rxs
		| h_txd | h_brg | h_osr;
	wire rd_rx  = acc & ~pwrite & (h_rxd | h_rxs);

	// ----------------------------------------
	// baud generation
	// ----------------------------------------
	// shared fractional divider feeds the divider
	// 32 kHz tick replaces it in low-rate mode
	wire src_tick = m32k ? rtc_tick : frg_tick;
	// os_tick may reach clk rate; 125 MHz covers 4.5 Mbit/s x16
	wire os_tick  = src_tick & (bcnt == '0);

	// ----------------------------------------
	// synchronous clock edges
	// ----------------------------------------
	// master uses its own pin, slave the incoming one
	wire sck     = smst ? sclk_o : sclk_i;
	wire rise    = sck & ~sck_q;
	wire fall    = ~sck & sck_q;
	wire samp_e  = spol ? fall : rise;
	wire shift_e = spol ? rise : fall;

	// ----------------------------------------
	// line selection
	// ----------------------------------------
	// loopback returns txd and rts internally
	wire rl      = loop ? txd : rxd;
	wire cts_e_n = loop ? rts_n : cts_n;

	// ----------------------------------------
	// transmitter control
	// ----------------------------------------
	// clear-to-send gates each new character
	wire cts_ok = ~ctsen | ~cts_e_n;
	// software disable holds the next character
	wire tx_go  = (tst == TX_IDLE) & en & ~txrdy & ~txdis & cts_ok;
	wire tx_adv = sync ? shift_e : (os_tick & (tos == osr));
	wire tx_end = (tst == TX_SEND) & tx_adv & (tleft == 4'h0);

	// ----------------------------------------
	// receiver control
	// ----------------------------------------
	wire ab_busy  = abaud | ab_on;
	wire rx_start = en & ~ab_busy & ~rl & (sync ? samp_e : os_tick);
	wire rbit_v   = (rst == RX_BITS) &
		(sync ? samp_e : (os_tick & (ros == mid + 4'h1)));
	// majority of three samples, mismatch is noise
	wire rbit     = sync ? rl : ((s1 & s2) | (s1 & rl) | (s2 & rl));
	wire noise_e  = ~sync & rbit_v & ~((s1 == s2) & (s2 == rl));
	wire rx_done  = rbit_v & (ridx == sp);
	wire frm      = ~rbit;
	wire brk_c    = rzero & ~rbit;
	wire perr     = par_en & (rpar != par_od);
	// address filter on the ninth bit
	wire accept   = rx_done &
		~(adet & (dsel == `USR_DLEN_9) & ~rsh[8]);
	wire ab_fin   = ab_on & rl;

	// ----------------------------------------
	// status and read mux
	// ----------------------------------------
	wire rx_brk = rst == RX_BRK;
	logic [31:0] live;
	logic [31:0] stat_v;
	logic [31:0] setv;
	logic [31:0] rdmux;
	always_comb begin
		live = '0;
		live[`USR_ST_RXRDY]  = rxrdy;
		live[`USR_ST_RXIDLE] = (rst == RX_IDLE) & ~ab_on;
		live[`USR_ST_TXRDY]  = txrdy;
		live[`USR_ST_TXIDLE] = tst == TX_IDLE;
		live[`USR_ST_CTS]    = ~cts_e_n;
		live[`USR_ST_TXDIS]  = txdis & (tst == TX_IDLE);
		live[`USR_ST_RXBRK]  = rx_brk;
		stat_v = live | stk;
		setv = '0;
		// any change of clear-to-send is flagged
		setv[`USR_ST_DCTS]  = cts_e_n != cts_q;
		setv[`USR_ST_OVR]   = accept & rxrdy & ~rd_rx;
		setv[`USR_ST_UNR]   = tx_end & sync & ~smst & ccont & txrdy;
		// break entry and exit both flagged
		setv[`USR_ST_DBRK]  = rx_brk != brk_q;
		setv[`USR_ST_FRM]   = accept & frm;
		setv[`USR_ST_PAR]   = accept & perr;
		setv[`USR_ST_NOISE] = noise_e;
		setv[`USR_ST_ABERR] = ab_fin & (ab_cnt == '0);
	end
	assign rdmux = h_cfg  ? cfg :
		h_ctl  ? ctl :
		h_stat ? stat_v :
		h_ien  ? inten :
		h_rxd  ? {23'h0, rxbuf} :
		// data and its status in one word
		h_rxs  ? {16'h0, rxst, 4'h0, rxbuf} :
		h_brg  ? {{(32-BRG_W){1'b0}}, brg} :
		h_osr  ? {28'h0, osr} : 32'h0;
	// enabled sources combine onto one line
	wire irq = |(stat_v & inten);

	// ----------------------------------------
	// apb slave: no wait states, answered from flops
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? rdmux : 32'h0;
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg   <= 32'h0;
			ctl   <= 32'h0;
			inten <= 32'h0;
			osr   <= `USR_OSR_RST;
		end else begin
			if (wr & h_cfg)
				cfg <= pwdata & `USR_CFG_MASK;
			if (wr & h_ien)
				inten <= pwdata & `USR_IEN_MASK;
			// factor below five is raised to five
			if (wr & h_osr)
				osr <= (pwdata[3:0] < `USR_OSR_MIN) ? `USR_OSR_MIN : pwdata[3:0];
			if (wr & h_ctl)
				ctl <= pwdata & `USR_CTL_MASK;
			else if (ab_fin)
				ctl[`USR_CTL_ABAUD] <= 1'b0;
		end
	end

	// a new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			stk <= 32'h0;
		else
			stk <= (stk & ~((wr & h_stat) ? pwdata & `USR_ST_W1C : 32'h0)) | setv;
	end

	// ----------------------------------------
	// divider and autobaud
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			brg    <= '0;
			bcnt   <= '0;
			ab_on  <= 1'b0;
			ab_sub <= 4'h0;
			ab_cnt <= '0;
		end else begin
			if (!en)
				bcnt <= '0;
			else if (src_tick)
				bcnt <= (bcnt == '0) ? brg : bcnt - 1'b1;
			if (wr & h_brg)
				brg <= pwdata[BRG_W-1:0];
			// start-bit length in units of osr+1 ticks
			if (en & abaud & ~ab_on & (rst == RX_IDLE) & ~rl) begin
				ab_on  <= 1'b1;
				ab_sub <= 4'h0;
				ab_cnt <= '0;
			end else if (ab_fin) begin
				ab_on <= 1'b0;
				if (ab_cnt != '0)
					brg <= ab_cnt[BRG_W-1:0] - 1'b1;
			end else if (ab_on & src_tick) begin
				ab_sub <= (ab_sub == osr) ? 4'h0 : ab_sub + 4'h1;
				if ((ab_sub == osr) & ~ab_cnt[BRG_W])
					ab_cnt <= ab_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tst   <= TX_IDLE;
			tsh   <= '1;
			tleft <= 4'h0;
			tos   <= 4'h0;
		end else if (!en) begin
			tst <= TX_IDLE;
		end else begin
			unique case (tst)
				TX_IDLE: if (tx_go) begin
					tsh   <= usr_frame(txbuf, dlen, par_en, par_od);
					tleft <= flen - 4'h1;
					tos   <= 4'h0;
					tst   <= TX_SEND;
				end
				TX_SEND: begin
					if (os_tick)
						tos <= (tos == osr) ? 4'h0 : tos + 4'h1;
					if (tx_adv) begin
						tsh   <= {1'b1, tsh[12:1]};
						tleft <= tleft - 4'h1;
					end
					if (tx_end)
						tst <= TX_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst   <= RX_IDLE;
			ros   <= 4'h0;
			ridx  <= 4'h0;
			rsh   <= 9'h0;
			rpar  <= 1'b0;
			rzero <= 1'b1;
			nz    <= 1'b0;
			s1    <= 1'b1;
			s2    <= 1'b1;
		end else if (!en) begin
			rst <= RX_IDLE;
		end else begin
			// tick count within one bit period
			// wraps to zero so a bit lasts osr+1 ticks, as on the transmit side
			if (os_tick)
				ros <= (rst == RX_IDLE) ? 4'h1 : (ros == osr) ? 4'h0 : ros + 4'h1;
			if (os_tick & (ros == mid - 4'h1))
				s1 <= rl;
			if (os_tick & (ros == mid))
				s2 <= rl;
			unique case (rst)
				RX_IDLE: if (rx_start) begin
					rst   <= RX_BITS;
					ridx  <= sync ? 4'h1 : 4'h0;
					rsh   <= 9'h0;
					rpar  <= 1'b0;
					rzero <= 1'b1;
					nz    <= 1'b0;
				end
				RX_BITS: if (rbit_v) begin
					ridx <= ridx + 4'h1;
					nz   <= nz | noise_e;
					if (ridx == 4'h0) begin
						if (rbit)
							rst <= RX_IDLE;
					end else if (ridx == sp) begin
						rst <= brk_c ? RX_BRK : RX_IDLE;
					end else begin
						if (ridx <= dlen)
							rsh[ridx-4'h1] <= rbit;
						rpar  <= rpar ^ rbit;
						rzero <= rzero & ~rbit;
					end
				end
				RX_BRK: if (rl)
					rst <= RX_IDLE;
				default: rst <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// data buffers
	// ----------------------------------------
	// single-entry buffers; overrun keeps the old character
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txbuf <= 9'h0;
			txrdy <= 1'b1;
			rxbuf <= 9'h0;
			rxst  <= 3'h0;
			rxrdy <= 1'b0;
		end else begin
			if (wr & h_txd) begin
				txbuf <= pwdata[8:0];
				txrdy <= 1'b0;
			end else if (tx_go) begin
				txrdy <= 1'b1;
			end
			if (accept & (~rxrdy | rd_rx)) begin
				rxbuf <= rsh;
				rxst  <= {nz | noise_e, perr, frm};
				rxrdy <= 1'b1;
			end else if (rd_rx) begin
				rxrdy <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// pins and event outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txd     <= 1'b1;
			rts_n   <= 1'b1;
			drv_oe  <= 1'b0;
			sclk_o  <= 1'b0;
			sclk_oe <= 1'b0;
			sck_q   <= 1'b0;
			cts_q   <= 1'b1;
			brk_q   <= 1'b0;
			intr    <= 1'b0;
			wake    <= 1'b0;
		end else begin
			txd    <= ~txbrk & ((tst == TX_SEND) ? tsh[0] : 1'b1);
			// request-to-send only while the buffer has room
			rts_n  <= ~en | rxrdy;
			// driver enable spans load through last stop bit
			drv_oe <= oesel & ((tst == TX_SEND) | tx_go | txbrk);
			// master clock runs per character or continuously
			if (!(en & sync & smst))
				sclk_o <= 1'b0;
			else if (os_tick & ((tst == TX_SEND) | (rst == RX_BITS) | ccont))
				sclk_o <= ~sclk_o;
			sclk_oe <= en & sync & smst;
			sck_q   <= sck;
			cts_q   <= cts_e_n;
			brk_q   <= rx_brk;
			intr    <= irq;
			// deep-sleep wake only in these three cases
			wake    <= irq & (sync | m32k | inten[`USR_ST_DCTS]);
		end
	end

	// dma requests follow the buffer flags
	assign rx_req = rxrdy;
	assign tx_req = txrdy;

endmodule
`default_nettype wire

/* tb/usr_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module usr_peer #(
	parameter int BT = 10
) (
	// clock
	input  wire logic clk,
	// serial side
	output logic      rxd,
	output logic      cts_n
);
	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
	end
	task set_cts(input logic v);
		@(posedge clk);
		cts_n <= v;
	endtask
	task send(input logic [12:0] f, input int n, input int g);
		for (int i = 0; i < n; i++) begin
			for (int c = 0; c < BT; c++) begin
				@(posedge clk);
				rxd <= (i == g && c inside {4, 5}) ? ~f[i] : f[i];
			end
		end
		@(posedge clk);
		rxd <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* tb/usr_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "usr_map.svh"
module usr_props (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// line and requests
	input wire logic        txd,
	input wire logic        rts_n,
	input wire logic        rx_req,
	input wire logic        tx_req,
	input wire logic        intr,
	input wire logic        wake
);
	wire setup = psel && !penable;
	wire fin = psel && penable && pready;
	wire mapped = paddr inside {`USR_A_CFG, `USR_A_CTL, `USR_A_STAT, `USR_A_INTEN,
		`USR_A_RXDAT, `USR_A_RXDST, `USR_A_TXDAT, `USR_A_BRG, `USR_A_OSR};
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_apb_ready: assert property (setup |=> pready)
		else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_map: assert property (setup |=> pslverr == !mapped)
		else $error("slave error does not match decode");
	a_rdata_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_txd_hold: assert property ($changed(txd) |=> $stable(txd))
		else $error("line bit shorter than two cycles");
	a_txbuf_take: assert property (fin && pwrite && paddr == `USR_A_TXDAT && tx_req
		|-> ##[1:2] !tx_req)
		else $error("transmit request not dropped");
	a_rxread_clr: assert property (fin && !pwrite && paddr == `USR_A_RXDAT && rx_req
		|-> ##[1:2] !rx_req)
		else $error("receive request not dropped");
	a_rts_throttle: assert property ($rose(rx_req) |-> ##[0:2] rts_n)
		else $error("rts still low with full buffer");
	a_wake_intr: assert property (wake |-> intr || $past(intr))
		else $error("wake without interrupt");
endmodule
bind usr_top usr_props u_props (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .txd, .rts_n, .rx_req, .tx_req, .intr, .wake);
`default_nettype wire

/* tb/usr_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "usr_map.svh"
module usr_top_tb;
	// bit time: osr 4 and brg 1 with a source tick every cycle
	localparam int BT = 10;
	logic        clk = 0;
	logic        reset_n = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready, pslverr, txd, rts_n, drv_oe, rx_req, tx_req, intr, wake, rxd, cts_n;
	int          n_errors = 0;
	int          num_checks = 0;
	always #4 clk = ~clk;
	usr_top uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .frg_tick(1'b1), .rtc_tick(1'b0), .rxd, .txd, .cts_n, .rts_n,
		.drv_oe, .sclk_i(1'b0), .sclk_o(), .sclk_oe(), .rx_req, .tx_req, .intr, .wake);
	usr_peer #(.BT(BT)) peer (.clk, .rxd, .cts_n);
	// ----
	// helpers
	// ----
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int k;
		k = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		e = pslverr;
		chk(pready, 1);
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1, a, d, q, e);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(0, a, 0, q, e);
		chk(q & m, x);
	endtask
	task waitfall(input int lim, output int k);
		k = 0;
		while (txd !== 1'b0 && k < lim) begin
			@(posedge clk);
			k++;
		end
	endtask
	task waitrx;
		int k;
		k = 0;
		while (rx_req !== 1'b1 && k < 300) begin
			@(posedge clk);
			k++;
		end
		chk(k < 300, 1);
	endtask
	function automatic logic [12:0] frm(input logic [1:0] dl, input logic [1:0] pr,
			input logic st, input logic [8:0] d, output int n);
		logic [8:0] m;
		frm = '1;
		frm[0] = 1'b0;
		m = 9'h1ff >> (2 - dl);
		n = 8 + dl;
		for (int i = 0; i < n - 1; i++)
			frm[i + 1] = d[i];
		if (pr[1]) begin
			frm[n] = pr[0] ^ (^(d & m));
			n++;
		end
		n = n + 1 + st;
	endfunction
	// ----
	// scenarios
	// ----
	task t_regs;
		logic [31:0] q;
		logic e;
		rdc(`USR_A_OSR, '1, 32'hf);
		rdc(`USR_A_CFG, '1, 32'h0);
		rdc(`USR_A_STAT, 32'h1f, 32'h1e);
		apb(0, 12'h010, 32'h0, q, e);
		chk({31'h0, e}, 1);
		chk(q, 0);
		wr(`USR_A_OSR, 32'h2);
		rdc(`USR_A_OSR, '1, 32'h4);
		wr(`USR_A_OSR, 32'h4);
		wr(`USR_A_BRG, 32'h1);
		chk(tx_req, 1);
		$display("t_regs done");
	endtask
	task tx_one(input logic [1:0] dl, input logic [1:0] pr, input logic st,
			input logic [8:0] d);
		logic [12:0] f;
		int n, k;
		f = frm(dl, pr, st, d, n);
		// driver enable selected so the rs-485 output can be judged
		wr(`USR_A_CFG, {11'h0, 1'b1, 13'h0, st, pr, dl, 2'b01});
		wr(`USR_A_TXDAT, {23'h0, d});
		waitfall(100, k);
		chk(k < 100, 1);
		repeat (BT / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			chk(txd, f[i]);
			if (i == 0 || i == n - 1)
				chk(drv_oe, 1);
			repeat (BT) @(posedge clk);
		end
	endtask
	task t_tx;
		tx_one(2'h0, 2'h0, 1'b0, 9'h05a);
		tx_one(2'h1, 2'h2, 1'b0, 9'h0a5);
		tx_one(2'h2, 2'h3, 1'b1, 9'h1c3);
		$display("t_tx done");
	endtask
	// kind: 0 clean, 1 bad parity, 2 low stop, 3 one noisy sample
	task rx_one(input logic [1:0] dl, input logic [1:0] pr, input logic [8:0] d,
			input int kind, input logic [31:0] fl);
		logic [12:0] f;
		int n;
		f = frm(dl, pr, 1'b0, d, n);
		if (kind == 1)
			f[n - 2] = ~f[n - 2];
		if (kind == 2)
			f[n - 1] = 1'b0;
		wr(`USR_A_CFG, {26'h0, pr, dl, 2'b01});
		peer.send(f, n, kind == 3 ? 3 : 99);
		waitrx;
		rdc(`USR_A_RXDST, 32'he1ff, fl | {23'h0, d});
		wr(`USR_A_STAT, `USR_ST_W1C);
	endtask
	task t_rx;
		rx_one(2'h1, 2'h0, 9'h0c3, 0, 32'h0);
		rx_one(2'h1, 2'h2, 9'h05a, 1, 32'h4000);
		rx_one(2'h1, 2'h0, 9'h0f0, 2, 32'h2000);
		rx_one(2'h1, 2'h0, 9'h055, 3, 32'h8000);
		rx_one(2'h2, 2'h3, 9'h1a6, 0, 32'h0);
		$display("t_rx done");
	endtask
	task t_ovr;
		wr(`USR_A_CFG, 32'h5);
		peer.send(13'h1e22, 10, 99);
		peer.send(13'h1e44, 10, 99);
		chk(rts_n, 1);
		rdc(`USR_A_STAT, 32'h101, 32'h101);
		rdc(`USR_A_RXDAT, 32'h1ff, 32'h11);
		wr(`USR_A_STAT, `USR_ST_W1C);
		$display("t_ovr done");
	endtask
	task t_flow;
		int k;
		wr(`USR_A_CFG, 32'h205);
		wr(`USR_A_INTEN, 32'h20);
		wr(`USR_A_STAT, `USR_ST_W1C);
		peer.set_cts(1'b1);
		wr(`USR_A_TXDAT, 32'h81);
		waitfall(50, k);
		chk(k, 50);
		rdc(`USR_A_STAT, 32'h30, 32'h20);
		chk({wake, intr}, 2'b11);
		peer.set_cts(1'b0);
		waitfall(50, k);
		chk(k < 50, 1);
		repeat (12 * BT) @(posedge clk);
		wr(`USR_A_CFG, 32'h5);
		wr(`USR_A_CTL, 32'h40);
		wr(`USR_A_TXDAT, 32'h7e);
		waitfall(50, k);
		chk(k, 50);
		rdc(`USR_A_STAT, 32'h40, 32'h40);
		wr(`USR_A_CTL, 32'h0);
		waitfall(50, k);
		chk(k < 50, 1);
		repeat (12 * BT) @(posedge clk);
		$display("t_flow done");
	endtask
	task t_brk;
		wr(`USR_A_CTL, 32'h2);
		repeat (4) @(posedge clk);
		chk(txd, 0);
		wr(`USR_A_CTL, 32'h0);
		repeat (4) @(posedge clk);
		chk(txd, 1);
		wr(`USR_A_STAT, `USR_ST_W1C);
		peer.send(13'h0, 12, 99);
		repeat (BT) @(posedge clk);
		rdc(`USR_A_STAT, 32'h800, 32'h800);
		rdc(`USR_A_RXDAT, 32'h1ff, 32'h0);
		wr(`USR_A_STAT, `USR_ST_W1C);
		$display("t_brk done");
	endtask
	task t_loop;
		wr(`USR_A_CFG, 32'h8005);
		wr(`USR_A_INTEN, 32'h1);
		wr(`USR_A_TXDAT, 32'h3c);
		waitrx;
		repeat (2) @(posedge clk);
		chk(intr, 1);
		chk(wake, 0);
		rdc(`USR_A_RXDAT, 32'h1ff, 32'h3c);
		wr(`USR_A_INTEN, 32'h0);
		$display("t_loop done");
	endtask
	task test_done;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		t_regs;
		t_tx;
		t_rx;
		t_ovr;
		t_flow;
		t_brk;
		t_loop;
		test_done;
	end
	// whole run needs well under ten thousand cycles
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		$display("ERROR t=%0t timeout", $time);
		test_done;
	end
endmodule
`default_nettype wire
